// ---- logic/adc_conversion_timing_sequencer.sv ----
// Conversion timing sequencer: divides ref_clk into the conversion clock and steps a
// four-channel scan through start time, delay or stabilisation wait, conversions and
// interrupt output delay. Registers over Avalon-MM with waitrequest.
// Assumes a single 50 MHz clock and an analog core that follows conv_active/conv_channel.
//
// Contract
// - Without stabilisation wait a scan takes start delay plus four conversions plus interrupt delay.
// - With stabilisation wait a scan takes the wait plus four conversions plus interrupt delay.
// - The first scan after enabling also spends the conversion start time.
// - Low-voltage mode with divide 001 uses clock/16, 1 start-delay, 80 conversion and 1 delay cycle.
// - Normal mode with wait and divide 001 uses clock/16, 4 wait, 64 conversion and 4 delay cycles.
// - In sequential mode with stabilisation wait the interrupt output delay is three conversion cycles shorter.
// - After a hardware trigger, later sequential scans skip start time and stabilisation wait.
// - The stabilisation wait counts from trigger detection or from the start bit being set.
//
// Added by the designer: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
module adc_conversion_timing_sequencer (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // Avalon-MM slave
   input wire logic [3:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   // Hardware trigger pin
   input wire logic hw_trigger,
   // Analog core control
   output logic conv_active,
   output logic conv_start,
   output logic [1:0] conv_channel,
   output logic scan_done,
   // Interrupt
   output logic irq
);

   // ****************************************
   // Bus slave
   // ****************************************
   logic waitrequest_q;
   logic [31:0] readdata_q;
   logic [9:0] ctrl_q;
   logic [1:0] status_q;
   logic [1:0] mask_q;
   logic irq_q;
   adc_seq_pkg::seq_state_t state_q;
   logic [7:0] cnt_q;
   logic [1:0] chan_q;

   // Access completes on the edge where waitrequest is low: one wait cycle per request
   wire req_w = read || write;
   wire take_w = req_w && !waitrequest_q;
   wire wr_w = write && !waitrequest_q;
   wire sel_ctrl_w = (address == adc_seq_pkg::OFF_CTRL);
   wire sel_status_w = (address == adc_seq_pkg::OFF_STATUS);
   wire sel_mask_w = (address == adc_seq_pkg::OFF_MASK);
   wire sel_state_w = (address == adc_seq_pkg::OFF_STATE);
   wire ctrl_wr_w = wr_w && sel_ctrl_w;

   always_ff @(posedge ref_clk) begin
      if (reset || take_w) begin
         waitrequest_q <= 1'b1;
      end else begin
         waitrequest_q <= !req_w;
      end
   end

   wire [31:0] rd_mux_w = sel_ctrl_w ? {22'h000000, ctrl_q} :
                          sel_status_w ? {30'h00000000, status_q} :
                          sel_mask_w ? {30'h00000000, mask_q} :
                          sel_state_w ? {24'h000000, 1'b0, state_q, 2'b00, chan_q} : 32'h00000000;

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         readdata_q <= 32'h00000000;
      end else if (read && waitrequest_q) begin
         readdata_q <= rd_mux_w;
      end
   end

   // ****************************************
   // Control fields and mode decode
   // ****************************************
   wire [2:0] div_sel_w = ctrl_q[adc_seq_pkg::DIV_LSB +: 3];
   wire lowv_w = ctrl_q[adc_seq_pkg::VMODE_LSB + 1];
   wire wait_w = ctrl_q[adc_seq_pkg::WAIT_BIT];
   wire seq_w = ctrl_q[adc_seq_pkg::SEQ_BIT];
   wire hw_en_w = ctrl_q[adc_seq_pkg::HWTRIG_BIT];
   wire enable_w = ctrl_q[adc_seq_pkg::ENABLE_BIT];
   wire start_w = ctrl_q[adc_seq_pkg::START_BIT];
   wire [15:0] wr_ctrl_w = writedata[15:0];
   wire wr_start_w = wr_ctrl_w[adc_seq_pkg::START_BIT];
   wire wr_enable_w = wr_ctrl_w[adc_seq_pkg::ENABLE_BIT];

   // Divide field 001 selects clock/16, every other code clock/32
   wire [5:0] div_len_w = (div_sel_w == adc_seq_pkg::DIV_SEL_16) ? adc_seq_pkg::DIV_FAST : adc_seq_pkg::DIV_SLOW;
   wire [7:0] conv_t_w = lowv_w ? adc_seq_pkg::CONV_LOWV_CYC : adc_seq_pkg::CONV_NORMAL_CYC;
   wire [7:0] delay_t_w = wait_w ? adc_seq_pkg::STAB_WAIT_CYC : adc_seq_pkg::START_DLY_CYC;
   // Only the wait tables carry a delay long enough to shorten; the no-wait delay is already one cycle
   wire [7:0] int_wait_w = seq_w ? adc_seq_pkg::INT_WAIT_CYC - adc_seq_pkg::SEQ_SHORTEN_CYC : adc_seq_pkg::INT_WAIT_CYC;
   wire [7:0] int_t_w = wait_w ? int_wait_w : adc_seq_pkg::INT_NOWAIT_CYC;

   // ****************************************
   // Scan sequencer
   // ****************************************
   logic tick;
   logic trig_rise;
   logic first_q;
   logic had_start_q;
   logic delay_used_q;
   logic conv_start_q;
   logic scan_done_q;
   logic conv_active_q;

   adc_fad_divider adc_fad_divider_inst (
      .ref_clk(ref_clk),
      .reset(reset),
      .restart(state_q == adc_seq_pkg::S_IDLE),
      .div_len(div_len_w),
      .tick(tick)
   );

   adc_trig_sync adc_trig_sync_inst (
      .ref_clk(ref_clk),
      .reset(reset),
      .pin(hw_trigger),
      .rise(trig_rise)
   );

   wire [7:0] target_w = (state_q == adc_seq_pkg::S_START) ? adc_seq_pkg::FIRST_START_CYC :
                         (state_q == adc_seq_pkg::S_DELAY) ? delay_t_w :
                         (state_q == adc_seq_pkg::S_CONV) ? conv_t_w : int_t_w;
   wire phase_last_w = tick && (cnt_q == target_w - 8'h01);
   wire idle_w = (state_q == adc_seq_pkg::S_IDLE);
   wire end_scan_w = (state_q == adc_seq_pkg::S_INTDLY) && phase_last_w;
   // A software scan starts in the cycle the start bit is written from 0 to 1
   wire sw_go_w = ctrl_wr_w && byteenable[1] && wr_start_w && !start_w && !hw_en_w && (enable_w || wr_enable_w);
   // A hardware scan starts in the cycle the filtered trigger edge is seen
   wire hw_go_w = trig_rise && hw_en_w && start_w && enable_w;
   wire go_w = idle_w && (sw_go_w || hw_go_w);
   wire abort_w = !idle_w && (!start_w || !enable_w);
   wire overrun_w = trig_rise && hw_en_w && start_w && enable_w && !idle_w;

   always_ff @(posedge ref_clk) begin
      if (reset || abort_w) begin
         state_q <= adc_seq_pkg::S_IDLE;
         chan_q <= 2'b00;
      end else begin
         case (state_q)
            adc_seq_pkg::S_IDLE: begin
               // First scan after enabling adds the conversion start time
               if (go_w) begin
                  state_q <= first_q ? adc_seq_pkg::S_START : adc_seq_pkg::S_DELAY;
               end
               chan_q <= 2'b00;
            end
            adc_seq_pkg::S_START: begin
               if (phase_last_w) begin
                  state_q <= adc_seq_pkg::S_DELAY;
               end
            end
            adc_seq_pkg::S_DELAY: begin
               if (phase_last_w) begin
                  state_q <= adc_seq_pkg::S_CONV;
               end
            end
            adc_seq_pkg::S_CONV: begin
               // Four channel conversions back to back
               if (phase_last_w && chan_q == adc_seq_pkg::LAST_CHANNEL) begin
                  state_q <= adc_seq_pkg::S_INTDLY;
               end else if (phase_last_w) begin
                  chan_q <= chan_q + 2'b01;
               end
            end
            adc_seq_pkg::S_INTDLY: begin
               // Sequential scans restart straight at the conversions, with no start time or wait
               if (phase_last_w) begin
                  state_q <= seq_w ? adc_seq_pkg::S_CONV : adc_seq_pkg::S_IDLE;
                  chan_q <= 2'b00;
               end
            end
            default: begin
               state_q <= adc_seq_pkg::S_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset || idle_w || phase_last_w) begin
         cnt_q <= 8'h00;
      end else if (tick) begin
         cnt_q <= cnt_q + 8'h01;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset || !enable_w) begin
         first_q <= 1'b1;
      end else if (state_q == adc_seq_pkg::S_START && phase_last_w) begin
         first_q <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         had_start_q <= 1'b0;
         delay_used_q <= 1'b0;
      end else if (go_w) begin
         had_start_q <= first_q;
         delay_used_q <= 1'b1;
      end else if (end_scan_w) begin
         had_start_q <= 1'b0;
         delay_used_q <= 1'b0;
      end
   end

   // ****************************************
   // Registers written by software
   // ****************************************
   wire [1:0] events_w = {overrun_w, end_scan_w};
   wire [1:0] w1c_w = (wr_w && sel_status_w && byteenable[0]) ? writedata[1:0] : 2'b00;

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         ctrl_q <= adc_seq_pkg::CTRL_RESET;
      end else if (ctrl_wr_w) begin
         ctrl_q[7:0] <= byteenable[0] ? wr_ctrl_w[7:0] : ctrl_q[7:0];
         ctrl_q[9:8] <= byteenable[1] ? wr_ctrl_w[9:8] : ctrl_q[9:8];
      end else if (end_scan_w && !seq_w && !hw_en_w) begin
         // One-shot software scan: start bit drops by itself at the end
         ctrl_q[adc_seq_pkg::START_BIT] <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         status_q <= adc_seq_pkg::STATUS_RESET;
         mask_q <= adc_seq_pkg::MASK_RESET;
         irq_q <= 1'b0;
      end else begin
         // Set beats clear so an event in the clearing cycle is kept
         status_q <= (status_q & ~w1c_w) | events_w;
         mask_q <= (wr_w && sel_mask_w && byteenable[0]) ? writedata[1:0] : mask_q;
         irq_q <= |(status_q & mask_q);
      end
   end

   // ****************************************
   // Analog core strobes
   // ****************************************
   wire next_conv_w = (state_q == adc_seq_pkg::S_DELAY && phase_last_w) ||
                      (state_q == adc_seq_pkg::S_CONV && phase_last_w && chan_q != adc_seq_pkg::LAST_CHANNEL) ||
                      (end_scan_w && seq_w);

   always_ff @(posedge ref_clk) begin
      if (reset || abort_w) begin
         conv_start_q <= 1'b0;
         scan_done_q <= 1'b0;
         conv_active_q <= 1'b0;
      end else begin
         conv_start_q <= next_conv_w;
         scan_done_q <= end_scan_w;
         conv_active_q <= next_conv_w ||
                          (state_q == adc_seq_pkg::S_CONV && !(phase_last_w && chan_q == adc_seq_pkg::LAST_CHANNEL));
      end
   end

   assign readdata = readdata_q;
   assign waitrequest = waitrequest_q;
   assign conv_active = conv_active_q;
   assign conv_start = conv_start_q;
   assign conv_channel = chan_q;
   assign scan_done = scan_done_q;
   assign irq = irq_q;

   // ****************************************
   // Checks
   // ****************************************
   logic [15:0] len_q;
   logic [15:0] phase_cyc_q;

   always_ff @(posedge ref_clk) begin
      if (reset || idle_w || end_scan_w) begin
         len_q <= 16'h0000;
      end else begin
         len_q <= len_q + 16'h0001;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset || idle_w || phase_last_w) begin
         phase_cyc_q <= 16'h0000;
      end else begin
         phase_cyc_q <= phase_cyc_q + 16'h0001;
      end
   end

   wire [15:0] conv4_w = {6'h00, conv_t_w, 2'b00};
   wire [15:0] scan_w = (16'(delay_t_w) + conv4_w + 16'(int_t_w)) * 16'(div_len_w) - 16'h0001;
   wire [15:0] first_w = scan_w + 16'(adc_seq_pkg::FIRST_START_CYC) * 16'(div_len_w);

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);

   sequence s_scan_end;
      (state_q == adc_seq_pkg::S_INTDLY) && phase_last_w;
   endsequence

   sequence s_done_pulse;
      scan_done_q ##1 !scan_done_q;
   endsequence

   a_nowait_scan_len: assert property (s_scan_end and (!wait_w && delay_used_q && !had_start_q) |-> len_q == scan_w)
      else $error("no-wait scan length wrong");
   a_wait_scan_len: assert property (s_scan_end and (wait_w && delay_used_q && !had_start_q) |-> len_q == scan_w)
      else $error("wait scan length wrong");
   a_first_scan_len: assert property (s_scan_end and had_start_q |-> len_q == first_w)
      else $error("first scan misses start time");
   a_lowv_conv_len: assert property ((state_q == adc_seq_pkg::S_CONV) && phase_last_w && lowv_w
      && div_sel_w == adc_seq_pkg::DIV_SEL_16 |-> phase_cyc_q == 16'h04FF)
      else $error("low-voltage conversion not 80 cycles of clock/16");
   a_normal_wait_len: assert property ((state_q == adc_seq_pkg::S_DELAY) && phase_last_w && wait_w && !lowv_w
      && div_sel_w == adc_seq_pkg::DIV_SEL_16 |-> phase_cyc_q == 16'h003F)
      else $error("normal stabilisation wait not 4 cycles of clock/16");
   a_seq_int_short: assert property (s_scan_end and (seq_w && wait_w) |-> phase_cyc_q == 16'(div_len_w) - 16'h0001)
      else $error("sequential interrupt delay not shortened");
   a_rescan_no_wait: assert property (s_scan_end and (seq_w && !abort_w) |=> state_q == adc_seq_pkg::S_CONV
      ##0 conv_start_q)
      else $error("sequential rescan repeated the wait");
   a_wait_from_start: assert property (go_w && !first_q && !abort_w |=> state_q == adc_seq_pkg::S_DELAY
      && phase_cyc_q == 16'h0000)
      else $error("wait does not start with the trigger");
   a_end_request: assert property (s_scan_end and !abort_w |=> s_done_pulse ##0 status_q[adc_seq_pkg::ST_DONE])
      else $error("conversion-end request missing");

endmodule

// ---- logic/adc_fad_divider.sv ----
// Conversion clock enable: one ref_clk-wide tick every div_len cycles.
// Assumes restart is held while the sequencer is idle, so a scan starts on a clean period.
`timescale 1ns/1ps
module adc_fad_divider (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // Control
   input wire logic restart,
   input wire logic [5:0] div_len,
   // Tick
   output logic tick
);
   logic [5:0] cnt_q;
   logic tick_q;
   wire last_w = (cnt_q == div_len - 6'h01);

   always_ff @(posedge ref_clk) begin
      if (reset || restart || last_w) begin
         cnt_q <= 6'h00;
      end else begin
         cnt_q <= cnt_q + 6'h01;
      end
   end

   // Registered one cycle ahead so tick lines up with the count it marks
   always_ff @(posedge ref_clk) begin
      if (reset || restart) begin
         tick_q <= 1'b0;
      end else begin
         tick_q <= (cnt_q == div_len - 6'h02);
      end
   end

   assign tick = tick_q;
endmodule

// ---- logic/adc_seq_pkg.sv ----
// Shared constants of the conversion timing sequencer: register map, field positions,
// reset values and timing counts in conversion-clock cycles.
// Assumes a 50 MHz ref_clk and a 32-bit Avalon-MM register port.
package adc_seq_pkg;

   // ****************************************
   // Register map (byte addresses)
   // ****************************************
   localparam logic [3:0] OFF_CTRL = 4'h0;
   localparam logic [3:0] OFF_STATUS = 4'h4;
   localparam logic [3:0] OFF_MASK = 4'h8;
   localparam logic [3:0] OFF_STATE = 4'hC;

   // ****************************************
   // Control fields
   // ****************************************
   localparam int DIV_LSB = 0;
   localparam int VMODE_LSB = 3;
   localparam int WAIT_BIT = 5;
   localparam int SEQ_BIT = 6;
   localparam int HWTRIG_BIT = 7;
   localparam int ENABLE_BIT = 8;
   localparam int START_BIT = 9;
   localparam logic [9:0] CTRL_RESET = 10'h000;
   localparam logic [2:0] DIV_SEL_16 = 3'h1;

   // Status / mask bits
   localparam int ST_DONE = 0;
   localparam int ST_OVERRUN = 1;
   localparam logic [1:0] STATUS_RESET = 2'h0;
   localparam logic [1:0] MASK_RESET = 2'h0;

   // ****************************************
   // Timing: divider lengths in ref_clk cycles, the rest in conversion-clock cycles
   // ****************************************
   localparam logic [5:0] DIV_SLOW = 6'h20;
   localparam logic [5:0] DIV_FAST = 6'h10;
   localparam logic [7:0] CONV_NORMAL_CYC = 8'h40;
   localparam logic [7:0] CONV_LOWV_CYC = 8'h50;
   localparam logic [7:0] START_DLY_CYC = 8'h01;
   localparam logic [7:0] STAB_WAIT_CYC = 8'h04;
   localparam logic [7:0] INT_NOWAIT_CYC = 8'h01;
   localparam logic [7:0] INT_WAIT_CYC = 8'h04;
   localparam logic [7:0] SEQ_SHORTEN_CYC = 8'h03;
   localparam logic [7:0] FIRST_START_CYC = 8'h02;
   localparam logic [1:0] LAST_CHANNEL = 2'h3;

   typedef enum logic [2:0] {S_IDLE, S_START, S_DELAY, S_CONV, S_INTDLY} seq_state_t;

endpackage

// ---- logic/adc_trig_sync.sv ----
// Hardware trigger pin synchroniser with agreement filter and rising-edge pulse.
// Assumes the pin is asynchronous to ref_clk.
`timescale 1ns/1ps
module adc_trig_sync (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // Pin
   input wire logic pin,
   // Filtered result
   output logic rise
);
   logic s1_q;
   logic s2_q;
   logic s3_q;
   logic level_q;
   logic rise_q;
   wire agree_w = (s2_q == s3_q);

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         level_q <= 1'b0;
         rise_q <= 1'b0;
      end else begin
         s1_q <= pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
         // A change counts only once two stages agree, which rejects a single metastable sample
         level_q <= agree_w ? s3_q : level_q;
         rise_q <= agree_w && s3_q && !level_q;
      end
   end

   assign rise = rise_q;
endmodule

// ---- verification/adc_core_model.sv ----
// Behavioural model of the analog sampling core that follows the conversion controls.
// Assumes conv_channel is valid while conv_start pulses.
`timescale 1ns/1ps
module adc_core_model (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // Conversion controls
   input wire logic conv_start,
   input wire logic [1:0] conv_channel,
   // Observations
   output int starts,
   output logic order_err
);
   logic [1:0] next_q;

   // A scan may restart at channel 0 after an abort, so 0 is always accepted
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         next_q <= 2'h0;
         starts <= 0;
         order_err <= 1'b0;
      end else if (conv_start === 1'b1) begin
         starts <= starts + 1;
         next_q <= conv_channel + 2'h1;
         if (conv_channel !== 2'h0 && conv_channel !== next_q) begin
            order_err <= 1'b1;
         end
      end
   end
endmodule

// ---- verification/test_adc_conversion_timing_sequencer.sv ----
// Self-checking bench of the conversion timing sequencer, driven over its register port.
// Assumes the design files and the analog core model are compiled before it.
`timescale 1ns/1ps
module test_adc_conversion_timing_sequencer;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic [3:0] address = 4'h0;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h0;
   logic [3:0] byteenable = 4'hF;
   logic hw_trigger = 1'b0;
   logic [31:0] readdata;
   logic waitrequest, conv_active, conv_start, scan_done, irq, order_err;
   logic [1:0] conv_channel;
   int starts, failures = 0, compares = 0, cyc = 0, t0 = 0, seed = 32'h10a4;
   logic [31:0] exp_rd[$];
   logic [31:0] fld = 32'h0;
   int exp_scan[$];
   localparam logic [31:0] en_m = 32'h1 << adc_seq_pkg::ENABLE_BIT;
   localparam logic [31:0] st_m = 32'h1 << adc_seq_pkg::START_BIT;

   adc_conversion_timing_sequencer adc_conversion_timing_sequencer_inst (.ref_clk(ref_clk), .reset(reset),
      .address(address), .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
      .readdata(readdata), .waitrequest(waitrequest), .hw_trigger(hw_trigger), .conv_active(conv_active),
      .conv_start(conv_start), .conv_channel(conv_channel), .scan_done(scan_done), .irq(irq));
   adc_core_model adc_core_model_inst (.ref_clk(ref_clk), .reset(reset), .conv_start(conv_start),
      .conv_channel(conv_channel), .starts(starts), .order_err(order_err));

   always #10 ref_clk = ~ref_clk;
   always @(posedge ref_clk) cyc <= cyc + 1;

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      compares++;
      if (s !== e) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic stop_test();
      $display("failures %0d compares %0d", failures, compares);
      if (failures == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   // Holds the request until waitrequest is sampled low; a write marks the scan reference time
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      read <= ~wr;
      write <= wr;
      address <= a;
      writedata <= d;
      do begin
         @(posedge ref_clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 100);
      read <= 1'b0;
      write <= 1'b0;
      if (wr) t0 = cyc;
      if (n >= 100) chk("waitrequest", 32'h0, 32'h1);
   endtask

   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      exp_rd.push_back(e);
      bus(1'b0, a, 32'h0);
   endtask

   // Stop with the old fields kept, let the settle time pass, then change fields while stopped
   task automatic cfg(input logic [31:0] f);
      bus(1'b1, adc_seq_pkg::OFF_CTRL, fld);
      repeat (10) @(posedge ref_clk);
      bus(1'b1, adc_seq_pkg::OFF_CTRL, f);
      fld = f;
      bus(1'b1, adc_seq_pkg::OFF_CTRL, f | en_m);
   endtask

   task automatic go(input logic [31:0] f);
      bus(1'b1, adc_seq_pkg::OFF_CTRL, f | en_m | st_m);
   endtask

   task automatic drain();
      int n;
      n = 0;
      while (exp_scan.size() > 0 && n < 40000) begin
         @(posedge ref_clk);
         n++;
      end
      chk("scan_queue", 32'h0, 32'(exp_scan.size()));
   endtask

   function automatic logic [31:0] ctl(input logic [2:0] dv, input logic [1:0] vm, input logic wt, sq, hw);
      ctl = 32'(dv) << adc_seq_pkg::DIV_LSB | 32'(vm) << adc_seq_pkg::VMODE_LSB
         | 32'(wt) << adc_seq_pkg::WAIT_BIT | 32'(sq) << adc_seq_pkg::SEQ_BIT | 32'(hw) << adc_seq_pkg::HWTRIG_BIT;
   endfunction

   // Scan time is judged with a few cycles of slack for trigger sync and registered pulses;
   // any wrong fAD count still misses by at least one divider period
   always @(posedge ref_clk) begin
      if (read && waitrequest === 1'b0 && exp_rd.size() > 0) chk("readdata", exp_rd.pop_front(), readdata);
      if (scan_done === 1'b1) begin
         compares++;
         if (exp_scan.size() == 0 || cyc - t0 < exp_scan[0] || cyc - t0 > exp_scan[0] + 10) begin
            failures++;
            $display("MISMATCH scan_time expected %0d seen %0d", exp_scan.size() ? exp_scan[0] : -1, cyc - t0);
         end
         if (exp_scan.size() > 0) void'(exp_scan.pop_front());
         t0 = cyc;
      end
   end

   // About 55000 cycles of tests; nearly twice that means a hang
   initial begin
      repeat (100000) @(posedge ref_clk);
      failures++;
      $display("MISMATCH watchdog expected finish seen timeout");
      stop_test();
   end

   // ****************************************
   // Scenarios
   // ****************************************
   initial begin
      logic [31:0] c, r;
      repeat (16) @(posedge ref_clk);
      reset <= 1'b0;
      rd(adc_seq_pkg::OFF_CTRL, 32'h0);
      rd(adc_seq_pkg::OFF_STATUS, 32'h0);
      rd(adc_seq_pkg::OFF_MASK, 32'h0);
      rd(adc_seq_pkg::OFF_STATE, 32'h0);
      r = $random(seed) & 32'hFF;
      bus(1'b1, adc_seq_pkg::OFF_CTRL, r);
      rd(adc_seq_pkg::OFF_CTRL, r);
      bus(1'b1, adc_seq_pkg::OFF_STATE, 32'hFF);
      rd(adc_seq_pkg::OFF_STATE, 32'h0);
      rd(4'h2, 32'h0);
      // Low-voltage, no wait, divide 001, first scan after enabling
      c = ctl(adc_seq_pkg::DIV_SEL_16, 2'h2, 1'b0, 1'b0, 1'b0);
      cfg(c);
      exp_scan.push_back((2 + 1 + 4 * 80 + 1) * 16);
      go(c);
      drain();
      rd(adc_seq_pkg::OFF_CTRL, c | en_m);
      rd(adc_seq_pkg::OFF_STATUS, 32'h1);
      chk("irq", 32'h0, {31'h0, irq});
      bus(1'b1, adc_seq_pkg::OFF_MASK, 32'h3);
      repeat (2) @(posedge ref_clk);
      chk("irq", 32'h1, {31'h0, irq});
      bus(1'b1, adc_seq_pkg::OFF_STATUS, 32'h1);
      repeat (2) @(posedge ref_clk);
      chk("irq", 32'h0, {31'h0, irq});
      // Normal, wait, divide 001: first scan then a repeat without start time
      c = ctl(adc_seq_pkg::DIV_SEL_16, 2'h1, 1'b1, 1'b0, 1'b0);
      cfg(c);
      exp_scan.push_back((2 + 4 + 4 * 64 + 4) * 16);
      go(c);
      drain();
      exp_scan.push_back((4 + 4 * 64 + 4) * 16);
      go(c);
      drain();
      // Sequential wait mode at a random slow divide code, then abort mid-scan
      r = $random(seed);
      c = ctl({r[2:1], 1'b0}, 2'h0, 1'b1, 1'b1, 1'b0);
      cfg(c);
      exp_scan.push_back((2 + 4 + 4 * 64 + 1) * 32);
      exp_scan.push_back((4 * 64 + 1) * 32);
      go(c);
      drain();
      repeat (3000) @(posedge ref_clk);
      chk("conv_active", 32'h1, {31'h0, conv_active});
      bus(1'b1, adc_seq_pkg::OFF_CTRL, c | en_m);
      repeat (2) @(posedge ref_clk);
      chk("conv_active", 32'h0, {31'h0, conv_active});
      rd(adc_seq_pkg::OFF_STATE, 32'h0);
      // Hardware trigger, low-voltage sequential wait mode, with a trigger overrun
      c = ctl(adc_seq_pkg::DIV_SEL_16, 2'h3, 1'b1, 1'b1, 1'b1);
      cfg(c);
      go(c);
      bus(1'b1, adc_seq_pkg::OFF_STATUS, 32'h3);
      exp_scan.push_back((2 + 4 + 4 * 80 + 1) * 16);
      exp_scan.push_back((4 * 80 + 1) * 16);
      @(posedge ref_clk);
      hw_trigger <= 1'b1;
      t0 = cyc;
      repeat (20) @(posedge ref_clk);
      hw_trigger <= 1'b0;
      repeat (2000) @(posedge ref_clk);
      hw_trigger <= 1'b1;
      repeat (20) @(posedge ref_clk);
      hw_trigger <= 1'b0;
      rd(adc_seq_pkg::OFF_STATUS, 32'h2);
      drain();
      bus(1'b1, adc_seq_pkg::OFF_CTRL, c);
      // Hardware one-shot, normal, no wait: a first scan and then a plain one
      c = ctl(adc_seq_pkg::DIV_SEL_16, 2'h0, 1'b0, 1'b0, 1'b1);
      cfg(c);
      go(c);
      exp_scan.push_back((2 + 1 + 4 * 64 + 1) * 16);
      exp_scan.push_back((1 + 4 * 64 + 1) * 16);
      repeat (2) begin
         hw_trigger <= 1'b1;
         t0 = cyc;
         repeat (20) @(posedge ref_clk);
         hw_trigger <= 1'b0;
         while (scan_done !== 1'b1) @(posedge ref_clk);
         @(posedge ref_clk);
      end
      drain();
      rd(adc_seq_pkg::OFF_STATE, 32'h0);
      bus(1'b1, adc_seq_pkg::OFF_CTRL, c);
      repeat (4) @(posedge ref_clk);
      chk("order_err", 32'h0, {31'h0, order_err});
      // Nine whole scans of four, plus three channel starts from the two rescans cut short
      chk("starts", 32'(9 * 4 + 3), 32'(starts));
      stop_test();
   end
endmodule
